// ---- vrs_pkg.sv ----
// Package: register map, field layout and reset values of the video refresh block
package vrs_pkg;
    // ==========================================================
    // Register addresses (bit addresses, as software issues them)
    localparam logic [31:0] VRS_ADDR_CTRL = 32'hc0000080;
    localparam logic [31:0] VRS_ADDR_LEGACY = 32'hc00001e0;
    localparam logic [31:0] VRS_ADDR_STEP_LO = 32'hc0000240;
    localparam logic [31:0] VRS_ADDR_STEP_HI = 32'hc0000250;
    // ==========================================================
    // Video control word fields
    localparam int VRS_HSD_BIT = 0;
    localparam int VRS_VSD_BIT = 1;
    localparam int VRS_CSD_BIT = 2;
    localparam int VRS_CVD_BIT = 3;
    localparam int VRS_SSV_BIT = 6;
    localparam int VRS_VCE_BIT = 7;
    localparam int VRS_CST_BIT = 11;
    localparam int VRS_SRE_BIT = 12;
    localparam int VRS_NIL_BIT = 14;
    localparam int VRS_ENV_BIT = 15;
    localparam logic [15:0] VRS_CTRL_MASK = 16'hd8cf;
    // ==========================================================
    // Display step word fields
    localparam int VRS_ZOOM_W = 5;
    localparam int VRS_STEP_LSB = 5;
    localparam int VRS_STEP_W = 27;
    // ==========================================================
    // Reset values
    localparam logic [15:0] VRS_CTRL_RST = 16'h0000;
    localparam logic [15:0] VRS_LEGACY_RST = 16'h0000;
    localparam logic [31:0] VRS_STEP_RST = 32'h00000000;
    localparam logic [VRS_ZOOM_W-1:0] VRS_RPT_RST = 5'h00;
endpackage : vrs_pkg

// ---- vrs_sync_edge.sv ----
// Two-flop synchroniser with start-of-pulse detect for an active-low sync pin
`timescale 1ns/1ps
`default_nettype none
module vrs_sync_edge (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic pin_n_in,
    output logic start_out
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // ==========================================================
    // Synchroniser; only the second stage is looked at
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
            start_out <= 1'b0;
        end else begin
            meta_r <= pin_n_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
            start_out <= prev_r & ~sync_r;
        end
    end
endmodule : vrs_sync_edge
`default_nettype wire

// ---- vrs_video_ctrl.sv ----
// Video control word, display step word, sync pin control and refresh address stepping
// How it works
// R1 - Step word: line-repeat code in bits 0-4, refresh row step in 5-31.
// R2 - Step word reached as 32 bits or low half at 240h, high half 250h.
// R3 - Zero code shows lines once; single bit 4..0 repeats 2,4,8,16,32 times.
// R4 - Software should clear line-repeat counter when changing code with video on.
// R5 - After each blanking refresh, add refresh row step to next refresh address.
// R6 - With zoom n, advance next refresh address only every nth refresh.
// R7 - Interlaced video advances next refresh address by twice the step.
// R8 - Legacy display word stores 16 bits and steers nothing.
// R9 - Control word fields at bits 0-3, 6, 7, 11, 12, 14, 15.
// R10 - Horizontal sync input: pulse start loads horizontal counter from preset.
// R11 - External horizontal pulse starts horizontal and composite intervals unless running.
// R12 - Horizontal direction 1 drives horizontal sync from timing values.
// R13 - Control bit 1 sets vertical sync direction; 0 is input.
// R14 - Vertical sync input: pulse start loads vertical counter, starts vertical interval.
// R15 - Vertical direction 1 drives vertical sync from timing values.
// R16 - Reserved control bits ignore writes and read as zero.
`timescale 1ns/1ps
`default_nettype none
module vrs_video_ctrl #(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic [31:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic reg_wide_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    input wire logic [CNT_W-1:0] horiz_preset_in,
    input wire logic [CNT_W-1:0] horiz_total_in,
    input wire logic [CNT_W-1:0] horiz_sync_end_in,
    input wire logic [CNT_W-1:0] vert_preset_in,
    input wire logic [CNT_W-1:0] vert_total_in,
    input wire logic [CNT_W-1:0] vert_sync_end_in,
    input wire logic [31:0] refresh_start_in,
    input wire logic repeat_clear_in,
    input wire logic hsync_n_in,
    output logic hsync_n_out,
    output logic hsync_oe_out,
    input wire logic vsync_n_in,
    output logic vsync_n_out,
    output logic vsync_oe_out,
    output logic csync_n_out,
    output logic csync_oe_out,
    output logic refresh_strobe_out,
    output logic [31:0] next_refresh_address_out,
    output logic [vrs_pkg::VRS_ZOOM_W-1:0] line_repeat_counter_out,
    output logic [CNT_W-1:0] horizontal_counter_out,
    output logic [CNT_W-1:0] vertical_counter_out
);
    import vrs_pkg::*;

    logic [15:0] video_control_word_r;
    logic [15:0] legacy_display_word_r;
    logic [31:0] display_step_word_r;
    logic [CNT_W-1:0] horizontal_counter_r;
    logic [CNT_W-1:0] vertical_counter_r;
    logic hsync_act_r;
    logic vsync_act_r;
    logic csync_act_r;
    logic [31:0] next_refresh_address_r;
    logic [VRS_ZOOM_W-1:0] line_repeat_counter_r;

    // ==========================================================
    // Register decode
    wire sel_ctrl = reg_addr_in == VRS_ADDR_CTRL;
    wire sel_legacy = reg_addr_in == VRS_ADDR_LEGACY;
    wire sel_lo = reg_addr_in == VRS_ADDR_STEP_LO;
    wire sel_hi = reg_addr_in == VRS_ADDR_STEP_HI;
    wire wr_lo = reg_wr_in & sel_lo; // [R2]
    wire wr_hi = reg_wr_in & ((sel_lo & reg_wide_in) | sel_hi); // [R2]
    wire [15:0] hi_wdata = sel_hi ? reg_wdata_in[15:0] : reg_wdata_in[31:16];
    wire [31:0] step_rd = sel_hi ? {16'h0000, display_step_word_r[31:16]} :
        (reg_wide_in ? display_step_word_r : {16'h0000, display_step_word_r[15:0]});
    wire [31:0] rd_mux = sel_ctrl ? {16'h0000, video_control_word_r} :
        sel_legacy ? {16'h0000, legacy_display_word_r} :
        (sel_lo | sel_hi) ? step_rd : 32'h00000000;

    // ==========================================================
    // Control fields
    wire horiz_sync_direction = video_control_word_r[VRS_HSD_BIT]; // [R9]
    wire vert_sync_direction = video_control_word_r[VRS_VSD_BIT]; // [R9] [R13]
    wire composite_sync_direction = video_control_word_r[VRS_CSD_BIT];
    wire composite_video_disable = video_control_word_r[VRS_CVD_BIT];
    wire screen_refresh_enable = video_control_word_r[VRS_SRE_BIT];
    wire noninterlace_enable = video_control_word_r[VRS_NIL_BIT];
    wire env = video_control_word_r[VRS_ENV_BIT];
    wire [VRS_ZOOM_W-1:0] line_repeat_code = display_step_word_r[VRS_ZOOM_W-1:0]; // [R1]
    wire [VRS_STEP_W-1:0] refresh_row_step = display_step_word_r[31:VRS_STEP_LSB]; // [R1]

    // ==========================================================
    // Sync pin inputs
    logic ext_hstart;
    logic ext_vstart;

    vrs_sync_edge u_hsync_edge (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .pin_n_in(hsync_n_in),
        .start_out(ext_hstart)
    );

    vrs_sync_edge u_vsync_edge (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .pin_n_in(vsync_n_in),
        .start_out(ext_vstart)
    );

    wire hload = ext_hstart & ~horiz_sync_direction; // [R10]
    wire vload = ext_vstart & ~vert_sync_direction; // [R14]

    // ==========================================================
    // Video timing counters
    wire line_end = horizontal_counter_r == horiz_total_in;
    wire frame_end = line_end & (vertical_counter_r == vert_total_in);
    wire [CNT_W-1:0] horizontal_counter_nxt = hload ? horiz_preset_in : // [R10]
        line_end ? '0 : horizontal_counter_r + 1'b1;
    wire [CNT_W-1:0] vertical_counter_nxt = vload ? vert_preset_in : // [R14]
        frame_end ? '0 : (line_end ? vertical_counter_r + 1'b1 : vertical_counter_r);
    // Interval starts come from the own timing or from an external pulse, whichever is first
    wire hsync_act_nxt = (line_end | hload) ? 1'b1 : // [R11]
        (horizontal_counter_r == horiz_sync_end_in) ? 1'b0 : hsync_act_r;
    wire csync_act_nxt = (line_end | hload) ? 1'b1 : // [R11]
        (horizontal_counter_r == horiz_sync_end_in) ? 1'b0 : csync_act_r;
    wire vsync_act_nxt = (frame_end | vload) ? 1'b1 : // [R14]
        (line_end & (vertical_counter_r == vert_sync_end_in)) ? 1'b0 : vsync_act_r;

    // ==========================================================
    // Refresh address stepping
    // Zoom factor n gives a compare limit of n-1 on the repeat counter
    function automatic logic [VRS_ZOOM_W-1:0] vrs_zoom_limit(input logic [VRS_ZOOM_W-1:0] code);
        case (code)
            5'h10: vrs_zoom_limit = 5'h01;
            5'h08: vrs_zoom_limit = 5'h03;
            5'h04: vrs_zoom_limit = 5'h07;
            5'h02: vrs_zoom_limit = 5'h0f;
            5'h01: vrs_zoom_limit = 5'h1f;
            default: vrs_zoom_limit = 5'h00;
        endcase
    endfunction : vrs_zoom_limit

    wire [VRS_ZOOM_W-1:0] zoom_limit = vrs_zoom_limit(line_repeat_code); // [R3]
    // Address is tracked even with refresh cycles off, as long as video is on
    wire refresh_evt = line_end & env;
    wire repeat_done = line_repeat_counter_r >= zoom_limit;
    wire advance = refresh_evt & repeat_done; // [R6]
    wire [31:0] step_eff = noninterlace_enable ? {5'h00, refresh_row_step} : // [R5]
        {4'h0, refresh_row_step, 1'b0}; // [R7]
    wire [31:0] addr_nxt = frame_end ? refresh_start_in :
        advance ? next_refresh_address_r + step_eff : next_refresh_address_r; // [R5]
    // A software clear of the counter is expected when the code changes with video on
    wire [VRS_ZOOM_W-1:0] rpt_nxt = (repeat_clear_in | frame_end | advance) ? VRS_RPT_RST : // [R4]
        refresh_evt ? line_repeat_counter_r + 1'b1 : line_repeat_counter_r; // [R6]

    // ==========================================================
    // Registers
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            video_control_word_r <= VRS_CTRL_RST;
            legacy_display_word_r <= VRS_LEGACY_RST;
            display_step_word_r <= VRS_STEP_RST;
            reg_rdata_out <= 32'h00000000;
        end else begin
            if (reg_wr_in & sel_ctrl) begin
                video_control_word_r <= reg_wdata_in[15:0] & VRS_CTRL_MASK; // [R9] [R16]
            end
            if (reg_wr_in & sel_legacy) begin
                legacy_display_word_r <= reg_wdata_in[15:0]; // [R8]
            end
            if (wr_lo) begin
                display_step_word_r[15:0] <= reg_wdata_in[15:0];
            end
            if (wr_hi) begin
                display_step_word_r[31:16] <= hi_wdata;
            end
            if (reg_rd_in) begin
                reg_rdata_out <= rd_mux;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            horizontal_counter_r <= '0;
            vertical_counter_r <= '0;
            hsync_act_r <= 1'b0;
            vsync_act_r <= 1'b0;
            csync_act_r <= 1'b0;
        end else begin
            horizontal_counter_r <= horizontal_counter_nxt;
            vertical_counter_r <= vertical_counter_nxt;
            hsync_act_r <= hsync_act_nxt;
            vsync_act_r <= vsync_act_nxt;
            csync_act_r <= csync_act_nxt;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            next_refresh_address_r <= 32'h00000000;
            line_repeat_counter_r <= VRS_RPT_RST;
            refresh_strobe_out <= 1'b0;
        end else begin
            next_refresh_address_r <= addr_nxt;
            line_repeat_counter_r <= rpt_nxt;
            refresh_strobe_out <= refresh_evt & screen_refresh_enable;
        end
    end

    // ==========================================================
    // Pin drivers, all registered
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hsync_n_out <= 1'b1;
            hsync_oe_out <= 1'b0;
            vsync_n_out <= 1'b1;
            vsync_oe_out <= 1'b0;
            csync_n_out <= 1'b1;
            csync_oe_out <= 1'b0;
        end else begin
            hsync_n_out <= ~hsync_act_r; // [R12]
            hsync_oe_out <= horiz_sync_direction; // [R12] [R10]
            vsync_n_out <= ~vsync_act_r; // [R15]
            vsync_oe_out <= vert_sync_direction; // [R15] [R13]
            // Blanking mode shows the horizontal interval; composite mixes both
            csync_n_out <= composite_video_disable ? ~hsync_act_r : ~(csync_act_r ^ vsync_act_r);
            csync_oe_out <= composite_sync_direction;
        end
    end

    assign next_refresh_address_out = next_refresh_address_r;
    assign line_repeat_counter_out = line_repeat_counter_r;
    assign horizontal_counter_out = horizontal_counter_r;
    assign vertical_counter_out = vertical_counter_r;

    // ==========================================================
    // Checks
    a_lo_half_write: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R2]
        reg_wr_in & sel_lo & ~reg_wide_in |=> display_step_word_r[31:16] ==
        $past(display_step_word_r[31:16]) && display_step_word_r[15:0] ==
        $past(reg_wdata_in[15:0]))
        else $error("low half write disturbed high half");
    a_hi_half_write: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R2]
        reg_wr_in & sel_hi |=> display_step_word_r[31:16] == $past(reg_wdata_in[15:0]))
        else $error("high half write not stored");
    a_reserved_zero: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R16]
        reg_rd_in & sel_ctrl |=> reg_rdata_out[10:8] == 3'h0 && reg_rdata_out[5:4] == 2'h0)
        else $error("reserved control bits read nonzero");
    a_legacy_inert: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R8]
        reg_rd_in & sel_legacy |=> reg_rdata_out == {16'h0000, $past(legacy_display_word_r)})
        else $error("legacy word readback wrong");
    a_ext_hload: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R10]
        ext_hstart & ~horiz_sync_direction |=> horizontal_counter_r == $past(horiz_preset_in) && hsync_act_r ##1
        hsync_n_out == 1'b0)
        else $error("external horizontal pulse not followed");
    a_ext_vload: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R14]
        ext_vstart & ~vert_sync_direction |=> vertical_counter_r == $past(vert_preset_in) && vsync_act_r)
        else $error("external vertical pulse not followed");
    a_hsync_dir: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R12]
        $rose(horiz_sync_direction) |=> hsync_oe_out ##1 hsync_oe_out == horiz_sync_direction)
        else $error("horizontal sync not driven");
    a_zoom_hold: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R6]
        refresh_evt & ~repeat_done & ~frame_end |=> $stable(next_refresh_address_r))
        else $error("address advanced inside repeat group");
    a_step_advance: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R5]
        advance & noninterlace_enable & ~frame_end |=> next_refresh_address_r ==
        $past(next_refresh_address_r) + {5'h00, $past(refresh_row_step)})
        else $error("noninterlaced step wrong");
    a_interlace_step: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R7]
        advance & ~noninterlace_enable & ~frame_end |=> next_refresh_address_r ==
        $past(next_refresh_address_r) + {4'h0, $past(refresh_row_step), 1'b0})
        else $error("interlaced step not doubled");
    a_zoom_once: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R3]
        refresh_evt & (line_repeat_code == 5'h00) |=> line_repeat_counter_r == VRS_RPT_RST)
        else $error("zero code still repeats lines");
    a_wide_write: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R2]
        reg_wr_in & sel_lo & reg_wide_in |=> display_step_word_r == $past(reg_wdata_in))
        else $error("wide step write not stored");
    a_ext_csync: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R11]
        ext_hstart & ~horiz_sync_direction |=> csync_act_r && hsync_act_r)
        else $error("external pulse did not start composite interval");
    a_vsync_dir: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R15]
        $rose(vert_sync_direction) |=> vsync_oe_out ##1 vsync_oe_out == vert_sync_direction)
        else $error("vertical sync not driven");
    a_csync_dir: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R9]
        $rose(composite_sync_direction) |=> csync_oe_out)
        else $error("composite sync not driven");
    // Edges on a pin the device drives itself must leave both counters running freely
    a_hsync_ignored: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R12]
        ext_hstart & horiz_sync_direction & ~line_end |=> horizontal_counter_r == $past(horizontal_counter_r) + 1'b1)
        else $error("horizontal pulse taken while driving");
    a_vsync_ignored: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R15]
        ext_vstart & vert_sync_direction & ~line_end |=> vertical_counter_r == $past(vertical_counter_r))
        else $error("vertical pulse taken while driving");
    a_rpt_clear: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R4]
        repeat_clear_in |=> line_repeat_counter_r == VRS_RPT_RST)
        else $error("repeat counter not cleared");
    a_strobe_gate: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R5]
        refresh_strobe_out |-> $past(screen_refresh_enable) && $past(env))
        else $error("refresh strobe without enables");
endmodule : vrs_video_ctrl
`default_nettype wire

// ---- vrs_sync_source.sv ----
// Partner model: external sync source on the horizontal and vertical sync pins
`timescale 1ns/1ps
`default_nettype none
module vrs_sync_source (
    input wire logic sys_clk_in,
    input wire logic hs_oe_in,
    input wire logic hs_drv_in,
    input wire logic vs_oe_in,
    input wire logic vs_drv_in,
    input wire logic hs_go_in,
    input wire logic vs_go_in,
    output logic hs_wire_out,
    output logic vs_wire_out
);
    // ==========================================================
    // Pulse generation
    // Pulses are four cycles wide; the pins are pulled up between pulses
    int hs_cnt = 0;
    int vs_cnt = 0;
    always @(posedge sys_clk_in) begin
        hs_cnt <= hs_go_in ? 4 : (hs_cnt > 0 ? hs_cnt - 1 : 0);
        vs_cnt <= vs_go_in ? 4 : (vs_cnt > 0 ? vs_cnt - 1 : 0);
    end
    // ==========================================================
    // Pin resolution: both sides pull low, so a pulse also reaches a pin the device drives
    assign hs_wire_out = (hs_oe_in ? hs_drv_in : 1'b1) & (hs_cnt == 0);
    assign vs_wire_out = (vs_oe_in ? vs_drv_in : 1'b1) & (vs_cnt == 0);
endmodule : vrs_sync_source
`default_nettype wire

// ---- tb.sv ----
// Testbench: register map, refresh address stepping and sync pin direction
`timescale 1ns/1ps
`default_nettype none
module tb;
    import vrs_pkg::*;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, wide = 0, rclr = 0, hgo = 0, vgo = 0;
    logic [31:0] addr = 0, wdata = 0, rdata, nra;
    logic [15:0] hpre = 16'h0300, htot = 16'h000f, vpre = 16'h0300, vtot = 16'hffff;
    logic [15:0] hcnt, vcnt;
    logic [4:0] rcnt;
    logic hs_w, vs_w, hs_o, hs_oe, vs_o, vs_oe, strobe, cs_o, cs_oe, e;
    int n_fail = 0, total_checks = 0, seed = 56;
    logic [31:0] m_step, m_a0, r;
    logic [15:0] m_legacy;
    logic [26:0] stp;
    logic [4:0] codes [6] = '{5'h00, 5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
    always #4 clk = ~clk;
    vrs_video_ctrl dut (.sys_clk_in(clk), .arst_n_in(rst_n), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_wide_in(wide), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .horiz_preset_in(hpre), .horiz_total_in(htot),
        .horiz_sync_end_in(16'h0004), .vert_preset_in(vpre), .vert_total_in(vtot),
        .vert_sync_end_in(16'h0002), .refresh_start_in(32'h00001000),
        .repeat_clear_in(rclr), .hsync_n_in(hs_w), .hsync_n_out(hs_o),
        .hsync_oe_out(hs_oe), .vsync_n_in(vs_w), .vsync_n_out(vs_o),
        .vsync_oe_out(vs_oe), .csync_n_out(cs_o), .csync_oe_out(cs_oe),
        .refresh_strobe_out(strobe), .next_refresh_address_out(nra),
        .line_repeat_counter_out(rcnt), .horizontal_counter_out(hcnt),
        .vertical_counter_out(vcnt));
    vrs_sync_source partner (.sys_clk_in(clk), .hs_oe_in(hs_oe), .hs_drv_in(hs_o),
        .vs_oe_in(vs_oe), .vs_drv_in(vs_o), .hs_go_in(hgo), .vs_go_in(vgo),
        .hs_wire_out(hs_w), .vs_wire_out(vs_w));
    // ==========================================================
    // Reporting
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    // ==========================================================
    // Register bus: one-cycle strobes launched at the falling edge
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d, input logic w);
        @(negedge clk);
        addr = a;
        wdata = d;
        wide = w;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [31:0] a, input logic w, output logic [31:0] d);
        @(negedge clk);
        addr = a;
        wide = w;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg
    // Bounded wait for one refresh strobe, leaves the bench at a falling edge
    task automatic wait_strobe;
        int k;
        k = 0;
        // Sampled at the falling edge, clear of the edge that launches the strobe
        do begin
            @(negedge clk);
            k++;
        end while (strobe !== 1'b1 && k < 100);
        if (strobe !== 1'b1) chk(32'h0, 32'h1, "no refresh strobe");
    endtask : wait_strobe
    // Fires an external pulse and reports whether the counter took its preset
    task automatic ext_pulse(input logic vert, input logic [31:0] exp);
        @(negedge clk);
        if (vert) vgo = 1'b1; else hgo = 1'b1;
        @(negedge clk);
        {vgo, hgo} = 2'b00;
        repeat (6) @(negedge clk);
        r = vert ? 32'(vcnt - vpre) : 32'(hcnt - hpre);
        chk(32'(r <= 2), exp, "counter preset load");
    endtask : ext_pulse
    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        rd_reg(VRS_ADDR_CTRL, 1'b0, r); chk(r, 32'h0, "ctrl reset");
        rd_reg(VRS_ADDR_STEP_LO, 1'b1, r); chk(r, 32'h0, "step reset");
        rd_reg(32'hc0000300, 1'b0, r); chk(r, 32'h0, "unmapped read");
        for (int i = 0; i < 8; i++) begin
            m_legacy = 16'($random(seed));
            wr_reg(VRS_ADDR_LEGACY, {16'h0, m_legacy}, 1'b0);
            rd_reg(VRS_ADDR_LEGACY, 1'b0, r); chk(r, {16'h0, m_legacy}, "legacy");
            r = $random(seed);
            wr_reg(VRS_ADDR_CTRL, r & 32'h0000bfff, 1'b0);
            rd_reg(VRS_ADDR_CTRL, 1'b0, m_step);
            chk(m_step, r & 32'h0000bfff & {16'h0000, VRS_CTRL_MASK}, "ctrl mask");
            chk({29'h0, vs_oe, hs_oe, 1'b0}, {29'h0, r[1:0], 1'b0}, "oe");
            r = $random(seed);
            wr_reg(VRS_ADDR_STEP_LO, r, 1'b1);
            wr_reg(VRS_ADDR_STEP_HI, {16'h0, ~r[31:16]}, 1'b0);
            rd_reg(VRS_ADDR_STEP_LO, 1'b1, m_step);
            chk(m_step, {~r[31:16], r[15:0]}, "step halves");
            rd_reg(VRS_ADDR_STEP_HI, 1'b0, m_step); chk(m_step, {16'h0, ~r[31:16]}, "hi");
            wr_reg(VRS_ADDR_STEP_LO, ~r, 1'b0);
            rd_reg(VRS_ADDR_STEP_LO, 1'b0, m_step);
            chk(m_step, {16'h0, ~r[15:0]}, "narrow low half");
            rd_reg(VRS_ADDR_STEP_LO, 1'b1, m_step);
            chk(m_step, ~r, "narrow write kept high half");
        end
        $display("test registers done");
        for (int noninterlace_enable = 0; noninterlace_enable < 2; noninterlace_enable++) begin
            for (int c = 0; c < 6; c++) begin
                stp = 27'($random(seed));
                wr_reg(VRS_ADDR_STEP_LO, {stp, codes[c]}, 1'b1);
                wr_reg(VRS_ADDR_CTRL, 32'h00009000 | (32'(noninterlace_enable) << 14), 1'b0);
                wait_strobe();
                rclr = 1'b1;
                @(negedge clk);
                rclr = 1'b0;
                m_a0 = nra;
                chk({27'h0, rcnt}, 32'h0, "repeat counter cleared");
                repeat ((1 << c) - 1) wait_strobe();
                chk(nra, m_a0, "address held while repeating");
                chk({27'h0, rcnt}, 32'((1 << c) - 1), "repeat count");
                wait_strobe();
                chk(nra, m_a0 + 32'(stp) * (noninterlace_enable ? 32'd1 : 32'd2), "address step");
            end
        end
        $display("test refresh done");
        htot = 16'h0fff;
        wr_reg(VRS_ADDR_CTRL, 32'h00008000, 1'b0);
        ext_pulse(1'b0, 32'h1);
        ext_pulse(1'b1, 32'h1);
        wr_reg(VRS_ADDR_CTRL, 32'h00008003, 1'b0);
        rst_n = 1'b0;
        // Short lines again so the driven horizontal and composite pins toggle during the checks below
        htot = 16'h000f;
        @(negedge clk);
        rst_n = 1'b1;
        wr_reg(VRS_ADDR_CTRL, 32'h0000800f, 1'b0);
        ext_pulse(1'b0, 32'h0);
        ext_pulse(1'b1, 32'h0);
        // Driven sync is low from two cycles after a line end up to one past the sync end count
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            e = !(hcnt >= 16'h0001 && hcnt <= 16'h0005);
            chk({31'h0, hs_o}, {31'h0, e}, "horizontal sync level");
            chk({30'h0, cs_oe, cs_o}, {30'h0, 1'b1, e}, "composite pin");
            chk({30'h0, vs_oe, vs_o}, {30'h0, 2'h3}, "vertical pin");
        end
        $display("test sync done");
        end_sim();
    end
    // Watchdog well beyond the expected run of about 2600 cycles
    initial begin
        #400000;
        n_fail++;
        end_sim();
    end
endmodule : tb
`default_nettype wire
